// >>> shared/scan_pkg.sv
package scan_pkg;

   // ----------------------------------------------------------------
   // Sizes of the I/O images and of the internal word memory
   // ----------------------------------------------------------------
   localparam int unsigned IN_POINTS  = 16;
   localparam int unsigned OUT_POINTS = 16;
   localparam int unsigned MEM_WORDS  = 16;
   localparam int unsigned ADDR_W     = 4;

   // Word that holds the output image, and first word of the latched area.
   localparam logic [ADDR_W-1:0] OUT_WORD_ADDR   = 4'h0;
   localparam logic [ADDR_W-1:0] LATCH_BASE_ADDR = 4'h8;

   // ----------------------------------------------------------------
   // Timing: scan times are counted in 0.1 ms units at a 50 MHz clock
   // ----------------------------------------------------------------
   localparam int unsigned CLOCK_PERIOD_NS = 20;
   localparam int unsigned SCAN_UNIT_NS    = 100000;
   localparam int unsigned UNIT_CYCLES     = SCAN_UNIT_NS / CLOCK_PERIOD_NS;

   // Reset values of the scan time registers, and the value at which the scan time count saturates.
   localparam logic [15:0] SCAN_TIME_RESET = 16'h0000;
   localparam logic [15:0] MIN_TIME_RESET  = 16'hFFFF;
   localparam logic [15:0] TIME_SATURATE   = 16'hFFFF;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {ST_STOPPED, ST_SAMPLE, ST_EVAL, ST_ISR, ST_REFRESH} scan_state_t;

   // Memory write from the program evaluator.
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [15:0]       data;
   } mem_write_t;

   // Direct refresh request: read samples inputs, write drives outputs.
   typedef struct packed {
      logic read_inputs;
      logic write_outputs;
   } direct_ref_t;

   // Scan time report.
   typedef struct packed {
      logic [15:0] current;
      logic [15:0] minimum;
      logic [15:0] maximum;
   } scan_times_t;

endpackage

// >>> rtl/plc_scan_cycle_sequencer.sv
// Function
// - Sample all inputs at each scan start.
// - Freeze input image until next scan.
// - Evaluate program on stored image until end.
// - Store results; upper memory words are latched.
// - On end, copy output image to pins.
// - Current scan time in 0.1 ms units.
// - Keep minimum and maximum scan time.
// - Interrupt suspends scan, runs subroutine, resumes.
// - Direct refresh accesses I/O mid evaluation.
`timescale 1ns/1ns
module plc_scan_cycle_sequencer
#(
   parameter int unsigned UNIT_CYCLES_P = scan_pkg::UNIT_CYCLES
)
(
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          sys_rst,
   // Run control from the controller
   input  wire logic                          run,
   // Physical points
   input  wire logic [scan_pkg::IN_POINTS-1:0]  in_pins,
   output logic      [scan_pkg::OUT_POINTS-1:0] out_pins,
   // Program evaluator
   output logic                               eval_start,
   output logic      [scan_pkg::IN_POINTS-1:0]  input_image,
   output logic                               eval_suspend,
   input  wire logic                          end_reached,
   input  wire scan_pkg::mem_write_t          mem_write,
   input  wire logic [scan_pkg::ADDR_W-1:0]   rd_addr,
   output logic      [15:0]                   rd_data,
   input  wire scan_pkg::direct_ref_t         direct_ref,
   // Interrupt subroutine handshake
   input  wire logic                          irq,
   output logic                               isr_start,
   input  wire logic                          isr_done,
   // Status
   output scan_pkg::scan_state_t              scan_state,
   output scan_pkg::scan_times_t              scan_times
);
   import scan_pkg::*;

   // ----------------------------------------------------------------
   // State of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      scan_state_t              fsm;
      logic [IN_POINTS-1:0]     sync_a;
      logic [IN_POINTS-1:0]     sync_b;
      logic [IN_POINTS-1:0]     sync_c;
      logic [IN_POINTS-1:0]     in_stable;
      logic [IN_POINTS-1:0]     in_image;
      logic [OUT_POINTS-1:0]    out_pins;
      logic [MEM_WORDS-1:0][15:0] mem;
      logic [15:0]              rd_data;
      logic                     eval_start;
      logic                     isr_start;
      logic                     suspend;
      logic                     irq_pending;
      logic                     first_scan;
      logic [15:0]              unit_cnt;
      logic [15:0]              scan_units;
      logic [15:0]              cur_time;
      logic [15:0]              min_time;
      logic [15:0]              max_time;
   } block_state_t;

   block_state_t state;
   block_state_t next_state;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // One process computes every register's next value from the state.
   always_comb
   begin
      next_state            = state;
      next_state.eval_start = 1'b0;
      next_state.isr_start  = 1'b0;

      // Inputs pass three flops; a bit is taken once the last two agree.
      next_state.sync_a = in_pins;
      next_state.sync_b = state.sync_a;
      next_state.sync_c = state.sync_b;
      for (int i = 0; i < IN_POINTS; i++)
      begin
         if (state.sync_b[i] == state.sync_c[i])
         begin
            next_state.in_stable[i] = state.sync_c[i];
         end
      end

      // Registered read port of the word memory.
      next_state.rd_data = state.mem[rd_addr];

      // Program results land in memory while the scan evaluates.
      if (mem_write.valid && (state.fsm == ST_EVAL || state.fsm == ST_ISR))
      begin
         next_state.mem[mem_write.addr] = mem_write.data;
      end

      // An interrupt request is held until the scan can take it; the clear on taking it wins.
      if (irq)
      begin
         next_state.irq_pending = 1'b1;
      end

      // Scan duration in 0.1 ms units, counted from the sampling phase.
      if (state.fsm != ST_STOPPED)
      begin
         if (state.unit_cnt == 16'(UNIT_CYCLES_P - 1))
         begin
            next_state.unit_cnt = 16'h0000;
            if (state.scan_units != TIME_SATURATE)
            begin
               next_state.scan_units = state.scan_units + 16'h0001;
            end
         end
         else
         begin
            next_state.unit_cnt = state.unit_cnt + 16'h0001;
         end
      end

      case (state.fsm)
         ST_STOPPED:
         begin
            if (run)
            begin
               // Non-latched words restart from zero on entry to run.
               for (int w = 0; w < MEM_WORDS; w++)
               begin
                  if (w < int'(LATCH_BASE_ADDR))
                  begin
                     next_state.mem[w] = 16'h0000;
                  end
               end
               next_state.first_scan = 1'b1;
               next_state.fsm        = ST_SAMPLE;
            end
         end
         ST_SAMPLE:
         begin
            // The image is taken here and nowhere else except direct refresh.
            next_state.in_image   = state.in_stable;
            next_state.unit_cnt   = 16'h0000;
            next_state.scan_units = 16'h0000;
            next_state.eval_start = 1'b1;
            next_state.fsm        = ST_EVAL;
         end
         ST_EVAL:
         begin
            if (end_reached)
            begin
               next_state.fsm = ST_REFRESH;
            end
            else if (state.irq_pending || irq)
            begin
               next_state.irq_pending = 1'b0;
               next_state.isr_start   = 1'b1;
               next_state.fsm         = ST_ISR;
            end
            else
            begin
               if (direct_ref.read_inputs)
               begin
                  next_state.in_image = state.in_stable;
               end
               if (direct_ref.write_outputs)
               begin
                  next_state.out_pins = state.mem[OUT_WORD_ADDR];
               end
            end
         end
         ST_ISR:
         begin
            if (isr_done)
            begin
               next_state.fsm = ST_EVAL;
            end
         end
         ST_REFRESH:
         begin
            next_state.out_pins = state.mem[OUT_WORD_ADDR];
            next_state.cur_time = state.scan_units;
            if (state.first_scan || state.scan_units < state.min_time)
            begin
               next_state.min_time = state.scan_units;
            end
            if (state.first_scan || state.scan_units > state.max_time)
            begin
               next_state.max_time = state.scan_units;
            end
            next_state.first_scan = 1'b0;
            next_state.fsm        = run ? ST_SAMPLE : ST_STOPPED;
         end
         default:
         begin
            next_state.fsm = ST_STOPPED;
         end
      endcase

      // The suspend flag is registered so that the evaluator sees a clean level.
      next_state.suspend = (next_state.fsm == ST_ISR);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Every field resets to a constant; the latched words start at zero.
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state          <= '0;
         state.fsm      <= ST_STOPPED;
         state.cur_time <= SCAN_TIME_RESET;
         state.min_time <= MIN_TIME_RESET;
         state.max_time <= SCAN_TIME_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign out_pins           = state.out_pins;
   assign eval_start         = state.eval_start;
   assign input_image        = state.in_image;
   assign eval_suspend       = state.suspend;
   assign rd_data            = state.rd_data;
   assign isr_start          = state.isr_start;
   assign scan_state         = state.fsm;
   assign scan_times.current = state.cur_time;
   assign scan_times.minimum = state.min_time;
   assign scan_times.maximum = state.max_time;

endmodule // plc_scan_cycle_sequencer

// >>> testbench/plc_scan_asserts.sv
`timescale 1ns/1ns
module plc_scan_asserts
#(
   parameter int unsigned UNIT_CYCLES_P = 10
)
(
   // Ports of the sequencer
   input wire logic                       clock,
   input wire logic                       sys_rst,
   input wire logic                       run,
   input wire logic [15:0]                out_pins,
   input wire logic                       eval_start,
   input wire logic [15:0]                input_image,
   input wire logic                       eval_suspend,
   input wire logic                       end_reached,
   input wire logic                       irq,
   input wire logic                       isr_start,
   input wire logic                       isr_done,
   input wire scan_pkg::direct_ref_t      direct_ref,
   input wire scan_pkg::scan_state_t      scan_state,
   input wire scan_pkg::scan_times_t      scan_times
);
   import scan_pkg::*;
   logic [31:0] cyc;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Counts cycles since the scan started, to bound the reported time.
   always_ff @(posedge clock or posedge sys_rst)
      if (sys_rst)
         cyc <= '0;
      else if (scan_state == ST_SAMPLE)
         cyc <= 32'h1;
      else
         cyc <= cyc + 32'h1;
   sequence s_end;
      scan_state == ST_EVAL && end_reached;
   endsequence
   sequence s_refresh;
      scan_state == ST_REFRESH ##1 scan_state == ST_SAMPLE;
   endsequence
   AST_SAMPLE_EVAL: assert property (scan_state == ST_SAMPLE |=>
      scan_state == ST_EVAL && eval_start) else $error("eval did not follow sample");
   AST_IMAGE_FROZEN: assert property (scan_state == ST_EVAL && !direct_ref.read_inputs
      |=> $stable(input_image)) else $error("input image moved mid scan");
   AST_END_REFRESH: assert property (s_end |=> s_refresh or
      (scan_state == ST_REFRESH && !run)) else $error("end did not refresh");
   AST_OUT_HOLD: assert property (!$stable(out_pins) |-> $past(scan_state) == ST_REFRESH
      || $past(direct_ref.write_outputs)) else $error("outputs moved outside refresh");
   AST_NEXT_SCAN: assert property (scan_state == ST_REFRESH && run |=>
      scan_state == ST_SAMPLE) else $error("next scan did not start");
   AST_IRQ_TAKEN: assert property (scan_state == ST_EVAL && irq && !end_reached |=>
      isr_start && eval_suspend) else $error("interrupt not taken");
   AST_ISR_RESUME: assert property (scan_state == ST_ISR && isr_done |=>
      scan_state == ST_EVAL && !eval_suspend) else $error("scan did not resume");
   AST_TIME_UNITS: assert property ($past(scan_state) == ST_REFRESH |->
      scan_times.current * UNIT_CYCLES_P <= cyc + UNIT_CYCLES_P
      && cyc < (scan_times.current + 2) * UNIT_CYCLES_P) else $error("scan time off");
   AST_MIN_MAX: assert property ($past(scan_state) == ST_REFRESH |->
      scan_times.minimum <= scan_times.current && scan_times.current <= scan_times.maximum)
      else $error("min or max not kept");
endmodule // plc_scan_asserts

// >>> testbench/io_points.sv
`timescale 1ns/1ns
module io_points
(
   // Physical input points
   output logic [scan_pkg::IN_POINTS-1:0] in_pins
);
   import scan_pkg::*;
   logic [IN_POINTS-1:0] level = '0;
   // Switches are wired straight to the input points.
   assign in_pins = level;
   // Sets a new switch pattern; called off the sampling edge.
   task automatic set_inputs(input logic [IN_POINTS-1:0] value);
      level = value;
   endtask
endmodule // io_points

// >>> testbench/tb_plc_scan_cycle_sequencer.sv
`timescale 1ns/1ns
module tb_plc_scan_cycle_sequencer;
   import scan_pkg::*;
   localparam int unsigned UNIT = 10;
   logic clock = 0, sys_rst = 1, run = 0, end_reached = 0, irq = 0, isr_done = 0;
   logic [15:0] in_pins, out_pins, input_image, rd_data, p, q, w, latched;
   logic [3:0] rd_addr = '0;
   logic eval_start, eval_suspend, isr_start;
   mem_write_t mem_write = '0;
   direct_ref_t direct_ref = '0;
   scan_state_t scan_state;
   scan_times_t scan_times;
   int mismatches = 0, checked = 0, cycles = 0;
   plc_scan_cycle_sequencer #(.UNIT_CYCLES_P(UNIT)) plc_scan_cycle_sequencer_inst (
      .clock(clock), .sys_rst(sys_rst), .run(run), .in_pins(in_pins), .out_pins(out_pins),
      .eval_start(eval_start), .input_image(input_image), .eval_suspend(eval_suspend),
      .end_reached(end_reached), .mem_write(mem_write), .rd_addr(rd_addr), .rd_data(rd_data),
      .direct_ref(direct_ref), .irq(irq), .isr_start(isr_start), .isr_done(isr_done),
      .scan_state(scan_state), .scan_times(scan_times));
   io_points io_points_inst (.in_pins(in_pins));
   // Clock and hang guard.
   always #10 clock = ~clock;
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         print_verdict();
      end
   end
   function automatic logic [15:0] units(input int n);
      return 16'(n / UNIT);
   endfunction
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Waits at falling edges until the scan state is reached.
   task automatic wait_state(input scan_state_t st);
      for (int n = 0; n < 200 && scan_state !== st; n++)
         @(negedge clock);
   endtask
   task automatic step();
      @(negedge clock);
   endtask
   // Plays the program evaluator through random scans.
   initial
   begin
      void'($urandom(69));
      p = 16'hA5C3;
      io_points_inst.set_inputs(p);
      repeat (3) step();
      sys_rst = 0;
      // Let the input pattern pass the pin synchroniser before the first scan.
      repeat (5) step();
      run = 1;
      for (int i = 0; i < 8; i++)
      begin
         wait_state(ST_EVAL);
         check("image", input_image, p);
         q = $urandom;
         w = $urandom;
         io_points_inst.set_inputs(q);
         mem_write = '{1'b1, OUT_WORD_ADDR, w};
         step();
         mem_write.valid = 0;
         repeat (5) step();
         check("frozen", input_image, p);
         if (i[0])
         begin
            irq = 1;
            step();
            irq = 0;
            check("suspend", {14'h0, isr_start, eval_suspend}, 16'h0003);
            latched = w;
            mem_write = '{1'b1, LATCH_BASE_ADDR, w};
            step();
            mem_write.valid = 0;
            isr_done = 1;
            step();
            isr_done = 0;
            check("resume", {13'h0, scan_state}, {13'h0, ST_EVAL});
         end
         else
         begin
            direct_ref = '{1'b1, 1'b1};
            step();
            direct_ref = '0;
            check("direct", out_pins, w);
            check("direct_read", input_image, q);
         end
         if (i == 7)
            repeat (60) step();
         end_reached = 1;
         step();
         end_reached = 0;
         wait_state(ST_SAMPLE);
         check("outputs", out_pins, w);
         p = q;
      end
      check("current", {15'h0, scan_times.current >= units(60)}, 16'h0001);
      check("maximum", {15'h0, scan_times.maximum >= units(60)}, 16'h0001);
      check("minimum", {15'h0, scan_times.minimum < units(60)}, 16'h0001);
      wait_state(ST_EVAL);
      run = 0;
      end_reached = 1;
      step();
      end_reached = 0;
      wait_state(ST_STOPPED);
      run = 1;
      wait_state(ST_EVAL);
      rd_addr = LATCH_BASE_ADDR;
      step();
      check("latched", rd_data, latched);
      rd_addr = OUT_WORD_ADDR;
      step();
      check("cleared", rd_data, 16'h0000);
      print_verdict();
   end
endmodule // tb_plc_scan_cycle_sequencer
bind plc_scan_cycle_sequencer plc_scan_asserts #(.UNIT_CYCLES_P(UNIT_CYCLES_P)) asserts_inst (
   .clock(clock), .sys_rst(sys_rst), .run(run), .out_pins(out_pins), .eval_start(eval_start),
   .input_image(input_image), .eval_suspend(eval_suspend), .end_reached(end_reached),
   .irq(irq), .isr_start(isr_start), .isr_done(isr_done), .direct_ref(direct_ref),
   .scan_state(scan_state), .scan_times(scan_times));
